//--- flash_seq_regs.svh
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// Register byte offsets
`define OFS_ADDR_LOW  8'h00
`define OFS_ADDR_HIGH 8'h04
`define OFS_DATA_LOW  8'h08
`define OFS_DATA_HIGH 8'h0C
`define OFS_CONTROL   8'h10
`define OFS_KEY       8'h14
`define OFS_STATUS    8'h18

// Control register bit positions
`define CTL_WR   1
`define CTL_ERR  3
`define CTL_FREE 4
`define CTL_LATCH_ONLY 5
`define CTL_CFG_SEL    6
`define CTL_WRITE_EN   2

// Status register bit positions
`define STAT_BUSY 0

// Unlock keys, in order
`define KEY_FIRST  8'h55
`define KEY_SECOND 8'hAA

// Latch geometry and blank value
`define LATCH_COUNT 32
`define LATCH_BLANK 14'h3FFF

// Bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

//--- flash_seq_pkg.sv
package flash_seq_pkg;

    typedef logic [13:0]       word_t;
    typedef word_t [31:0]      latch_row_t;

    typedef enum logic [1:0] {UK_NONE, UK_GOT1, UK_ARMED} unlock_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_LOAD, SQ_PROG, SQ_ERASE} seq_t;

    // Request to the flash array
    typedef struct packed {
        logic        prog;
        logic        erase;
        logic [9:0]  row;
    } flash_req_t;

    // Latch bank state
    typedef struct packed {
        latch_row_t  row;
    } bank_state_t;

    // Sequencer and bus slave state
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_full;
        logic [7:0]  awaddr;
        logic        w_full;
        logic [7:0]  wbyte;
        logic        wlane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [14:0] addr;
        word_t       wd;
        logic        write_enable_bit;
        logic        config_space_select;
        logic        latch_only_bit;
        logic        free;
        logic        wr;
        logic        err;
        unlock_t     ukey;
        seq_t        sq;
        logic        ld;
        logic [4:0]  ld_idx;
        word_t       ld_data;
        logic        blank;
        flash_req_t  req;
    } seq_state_t;

endpackage : flash_seq_pkg

//--- flash_latch_bank.sv
`timescale 1ns/1ps
`include "flash_seq_regs.svh"

module flash_latch_bank
    import flash_seq_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       load,
    input  wire logic [4:0] idx,
    input  wire word_t      data,
    input  wire logic       blank,
    output latch_row_t      row
);

    bank_state_t st_r;
    bank_state_t st_nxt;
    latch_row_t  ent_nxt;

    // Per latch: a load wins, else blank, else hold
    genvar g;
    generate
        for (g = 0; g < `LATCH_COUNT; g++)
        begin : g_latch
            assign ent_nxt[g] = (load && idx == 5'(g)) ? data :
                                blank ? `LATCH_BLANK :
                                st_r.row[g];
        end
    endgenerate

    // Next state
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.row = ent_nxt;
    end

    // State register, latches start blank
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_r <= {`LATCH_COUNT{`LATCH_BLANK}};
        else
            st_r <= st_nxt;
    end

    assign row = st_r.row;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_blank_all_latches: assert property (blank && !load |=>
        row == {`LATCH_COUNT{`LATCH_BLANK}})
        else $error("latches not blank after completion");

    a_load_one_latch: assert property (load |=>
        row[$past(idx)] == $past(data))
        else $error("addressed latch not loaded");

endmodule : flash_latch_bank

//--- flash_row_write_sequencer.sv
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"


module flash_row_write_sequencer
    import flash_seq_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        flash_done,
    output flash_req_t       flash_req,
    output latch_row_t       latch_row
);

    seq_state_t r;
    seq_state_t n;
    logic [7:0] cb;
    logic       go;

    // Bus slave, unlock tracking and sequencer
    always_comb
    begin
        n       = r;
        cb      = r.wbyte;
        go      = 1'b0;
        n.ld    = 1'b0;
        n.blank = 1'b0;

        // Address and data are taken in either order
        if (awvalid && r.awready)
        begin
            n.aw_full = 1'b1;
            n.awaddr  = awaddr;
        end
        if (wvalid && r.wready)
        begin
            n.w_full = 1'b1;
            n.wbyte  = wdata[7:0];
            n.wlane  = wstrb[0];
        end
        if (bready && r.bvalid)
            n.bvalid = 1'b0;

        // Flash operation progress
        case (r.sq)
            SQ_LOAD:
            begin
                n.req.prog = 1'b1;
                n.sq       = SQ_PROG;
            end
            SQ_PROG, SQ_ERASE:
            begin
                if (flash_done)
                begin
                    n.req.prog  = 1'b0;
                    n.req.erase = 1'b0;
                    n.blank     = 1'b1;
                    n.wr        = 1'b0;
                    n.sq        = SQ_IDLE;
                end
            end
            default:
            begin
            end
        endcase

        // Register write once both halves are held
        if (r.aw_full && r.w_full && !r.bvalid)
        begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `RESP_OKAY;
            n.ukey    = UK_NONE;
            case (r.awaddr)
                `OFS_ADDR_LOW:
                begin
                    if (r.wlane)
                        n.addr[7:0] = cb;
                end
                `OFS_ADDR_HIGH:
                begin
                    if (r.wlane)
                        n.addr[14:8] = cb[6:0];
                end
                `OFS_DATA_LOW:
                begin
                    if (r.wlane)
                        n.wd[7:0] = cb;
                end
                `OFS_DATA_HIGH:
                begin
                    if (r.wlane)
                        n.wd[13:8] = cb[5:0];
                end
                `OFS_KEY:
                begin
                    // Two keys in a row arm the unlock
                    if (r.wlane && cb == `KEY_FIRST)
                        n.ukey = UK_GOT1;
                    else if (r.wlane && cb == `KEY_SECOND && r.ukey == UK_GOT1)
                        n.ukey = UK_ARMED;
                end
                `OFS_CONTROL:
                begin
                    if (r.wlane)
                    begin
                        n.write_enable_bit    = cb[`CTL_WRITE_EN];
                        n.config_space_select = cb[`CTL_CFG_SEL];
                        n.latch_only_bit      = cb[`CTL_LATCH_ONLY];
                        n.free = cb[`CTL_FREE];
                        if (!cb[`CTL_ERR])
                            n.err = 1'b0;
                        if (cb[`CTL_WR] && !r.wr)
                        begin
                            // Start only after a full unlock
                            if (r.ukey == UK_ARMED && cb[`CTL_WRITE_EN] && !cb[`CTL_CFG_SEL])
                                go = 1'b1;
                            else
                                n.err = 1'b1;  // Set wins over clear
                        end
                    end
                end
                `OFS_STATUS:
                begin
                end
                default:
                    n.bresp = `RESP_SLVERR;
            endcase
        end

        // Completed unlock: erase row, or load latch and maybe program
        if (go)
        begin
            if (cb[`CTL_FREE])
            begin
                n.wr        = 1'b1;
                n.req.erase = 1'b1;
                n.req.row   = r.addr[14:5];
                n.sq        = SQ_ERASE;
            end
            else
            begin
                n.ld      = 1'b1;
                n.ld_idx  = r.addr[4:0];
                n.ld_data = r.wd;
                if (!cb[`CTL_LATCH_ONLY])
                begin
                    n.wr      = 1'b1;
                    n.req.row = r.addr[14:5];
                    n.sq      = SQ_LOAD;
                end
            end
        end

        // Read channel
        if (rready && r.rvalid)
        begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end
        if (arvalid && r.arready)
        begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rresp   = `RESP_OKAY;
            n.rdata   = 32'h0000_0000;
            case (araddr)
                `OFS_ADDR_LOW:
                    n.rdata[7:0] = r.addr[7:0];
                `OFS_ADDR_HIGH:
                    n.rdata[6:0] = r.addr[14:8];
                `OFS_DATA_LOW:
                    n.rdata[7:0] = r.wd[7:0];
                `OFS_DATA_HIGH:
                    n.rdata[5:0] = r.wd[13:8];
                `OFS_CONTROL:
                begin
                    n.rdata[`CTL_WR]         = r.wr;
                    n.rdata[`CTL_WRITE_EN]   = r.write_enable_bit;
                    n.rdata[`CTL_ERR]        = r.err;
                    n.rdata[`CTL_FREE]       = r.free;
                    n.rdata[`CTL_LATCH_ONLY] = r.latch_only_bit;
                    n.rdata[`CTL_CFG_SEL]    = r.config_space_select;
                end
                `OFS_KEY:
                begin
                end
                `OFS_STATUS:
                begin
                    n.rdata[`STAT_BUSY] = (r.sq != SQ_IDLE);
                    n.rdata[2:1]        = r.sq;
                    n.rdata[4:3]        = r.ukey;
                end
                default:
                    n.rresp = `RESP_SLVERR;
            endcase
        end

        // Ready only while a slot is free
        n.awready = !n.aw_full && !n.bvalid;
        n.wready  = !n.w_full && !n.bvalid;
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r         <= '0;
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // Outputs straight from state
    assign awready   = r.awready;
    assign wready    = r.wready;
    assign bvalid    = r.bvalid;
    assign bresp     = r.bresp;
    assign arready   = r.arready;
    assign rvalid    = r.rvalid;
    assign rdata     = r.rdata;
    assign rresp     = r.rresp;
    assign flash_req = r.req;

    // Write latches
    flash_latch_bank u_bank (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (r.ld),
        .idx     (r.ld_idx),
        .data    (r.ld_data),
        .blank   (r.blank),
        .row     (latch_row)
    );

    default clocking dcb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_no_auto_erase: assert property (r.req.prog |-> !r.req.erase)
        else $error("erase raised during program");

    a_erase_whole_row: assert property (r.req.erase && $past(r.req.erase)
        |-> $stable(r.req.row) && r.sq == SQ_ERASE)
        else $error("erase row changed mid operation");

    // Erase never loads a latch
    a_erase_no_load: assert property (r.sq == SQ_ERASE |-> !r.ld)
        else $error("latch loaded during erase");

    a_refused_start: assert property ($rose(r.err) |-> !r.ld && r.sq == SQ_IDLE)
        else $error("refused start still acted");

    a_row_fixed: assert property (r.req.prog && $past(r.req.prog)
        |-> $stable(r.req.row))
        else $error("program row changed mid operation");

    a_load_unlocked: assert property (r.ld |-> $past(r.ukey) == UK_ARMED)
        else $error("latch loaded without unlock");

    a_latch_only: assert property (r.ld && r.sq == SQ_IDLE
        |=> !r.req.prog [*2])
        else $error("program started in latch-only mode");

    a_commit_row: assert property (r.sq == SQ_LOAD
        |=> r.req.prog && latch_row[$past(r.ld_idx)] == $past(r.ld_data))
        else $error("commit did not program loaded row");

    a_blank_after: assert property ((r.req.prog || r.req.erase) && flash_done
        |=> r.blank && !r.wr ##1 latch_row == {`LATCH_COUNT{`LATCH_BLANK}} || r.ld)
        else $error("latches not blanked after operation");

    a_index_sample: assert property (r.ld
        |-> r.ld_idx == $past(r.addr[4:0]) && r.ld_data == $past(r.wd))
        else $error("latch index not taken at unlock");

endmodule : flash_row_write_sequencer

//--- flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model
    import flash_seq_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire flash_req_t flash_req,
    input  wire logic [3:0] delay,
    output logic            flash_done
);
    logic [3:0] cnt_r;
    logic       fin_r;

    // One done pulse per request, after a settable delay
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r      <= 4'h0;
            fin_r      <= 1'b0;
            flash_done <= 1'b0;
        end
        else
        begin
            flash_done <= 1'b0;
            if (!(flash_req.prog || flash_req.erase))
            begin
                cnt_r <= 4'h0;
                fin_r <= 1'b0;
            end
            else if (!fin_r && cnt_r == delay)
            begin
                flash_done <= 1'b1;
                fin_r      <= 1'b1;
            end
            else if (!fin_r)
            begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule : flash_array_model

//--- tb_flash_row_write_sequencer.sv
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module tb_flash_row_write_sequencer
    import flash_seq_pkg::*;
;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0, awready, wready, flash_done;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0]  wstrb = 4'h0, flash_delay = 4'h5, strb = 4'hF;
    logic [1:0]  bresp, rresp, r, rr;
    flash_req_t  flash_req;
    latch_row_t  latch_row;
    int          err_count = 0, checks_done = 0;
    typedef struct { logic [7:0] a; logic [31:0] d; logic [1:0] resp; logic [31:0] q; } case_t;
    case_t rows [8] = '{'{8'h00, 32'hA5, 2'h0, 32'hA5}, '{8'h04, 32'h55, 2'h0, 32'h55},
        '{8'h08, 32'h3C, 2'h0, 32'h3C}, '{8'h0C, 32'h2A, 2'h0, 32'h2A},
        '{8'h10, 32'h24, 2'h0, 32'h24}, '{8'h14, 32'h11, 2'h0, 32'h00},
        '{8'h18, 32'hFF, 2'h0, 32'h00}, '{8'h1C, 32'h77, 2'h2, 32'h00}};

    // Clock, 50 ns period
    always #25 aclk = ~aclk;

    flash_row_write_sequencer flash_row_write_sequencer_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .flash_done(flash_done), .flash_req(flash_req),
        .latch_row(latch_row));
    flash_array_model flash_array_model_inst (.aclk(aclk), .aresetn(aresetn),
        .flash_req(flash_req), .delay(flash_delay), .flash_done(flash_done));

    task end_sim;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Write: address and data offered together, bready held until bvalid
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= strb;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid === 1'b1 && bready));
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid === 1'b1 && rready));
        q = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask : rd

    task unlock(input logic [31:0] ctl);
        wr(`OFS_KEY, `KEY_FIRST);
        wr(`OFS_KEY, `KEY_SECOND);
        wr(`OFS_CONTROL, ctl);
    endtask : unlock

    // Bounded wait for a flash request level
    task wait_busy(input logic lvl);
        int n;
        n = 0;
        while (((flash_req.prog | flash_req.erase) !== lvl) && n < 40)
        begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_busy

    // Blanking lands one edge after the request drops
    task chk_blank;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 32; i++) chk(latch_row[i], `LATCH_BLANK);
    endtask : chk_blank

    // Watchdog
    initial
    begin
        repeat (4000) @(posedge aclk);
        err_count++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk(flash_req, 32'h0);
        chk_blank();
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk(r, rows[i].resp);
            rd(rows[i].a);
            chk(rr, rows[i].resp);
            chk(q, rows[i].q);
        end
        // Lane 0 strobe off leaves the register alone
        strb = 4'h0;
        wr(`OFS_ADDR_LOW, 32'hFF);
        strb = 4'hF;
        chk(r, `RESP_OKAY);
        rd(`OFS_ADDR_LOW);
        chk(q, 32'hA5);
        // Latch-only load of entry 3, row 8
        wr(`OFS_ADDR_HIGH, 32'h01); wr(`OFS_ADDR_LOW, 32'h03);
        wr(`OFS_DATA_LOW, 32'hBC); wr(`OFS_DATA_HIGH, 32'h12);
        unlock(32'h26);
        repeat (4) @(posedge aclk);
        chk(latch_row[3], 32'h12BC);
        chk(latch_row[4], `LATCH_BLANK);
        chk(flash_req, 32'h0);
        wr(`OFS_DATA_LOW, 32'h00);
        chk(latch_row[3], 32'h12BC);
        // Unlock broken by an address write
        wr(`OFS_KEY, `KEY_FIRST); wr(`OFS_ADDR_LOW, 32'h04);
        wr(`OFS_KEY, `KEY_SECOND); wr(`OFS_CONTROL, 32'h26);
        repeat (4) @(posedge aclk);
        rd(`OFS_CONTROL);
        chk(q, 32'h2C);
        chk(latch_row[4], `LATCH_BLANK);
        chk(flash_req, 32'h0);
        // Start refused while configuration space is selected
        wr(`OFS_CONTROL, 32'h24);
        unlock(32'h46);
        repeat (4) @(posedge aclk);
        rd(`OFS_CONTROL);
        chk(q, 32'h4C);
        chk(latch_row[4], `LATCH_BLANK);
        wr(`OFS_CONTROL, 32'h24);
        // Commit last entry 31 with latch-only clear, slow flash
        wr(`OFS_ADDR_LOW, 32'h1F); wr(`OFS_DATA_LOW, 32'h77);
        wr(`OFS_DATA_HIGH, 32'h01);
        unlock(32'h06);
        wait_busy(1'b1);
        chk(flash_req.prog, 1'b1);
        chk(flash_req.erase, 1'b0);
        chk(flash_req.row, 32'h008);
        chk(latch_row[31], 32'h0177);
        chk(latch_row[3], 32'h12BC);
        rd(`OFS_STATUS);
        chk(q, 32'h05);
        wait_busy(1'b0);
        chk_blank();
        // Partial load then row erase, prompt flash; data high still 01
        flash_delay <= 4'h0;
        wr(`OFS_ADDR_HIGH, 32'h02); wr(`OFS_ADDR_LOW, 32'h45); wr(`OFS_DATA_LOW, 32'h99);
        unlock(32'h26);
        repeat (4) @(posedge aclk);
        chk(latch_row[5], 32'h0199);
        unlock(32'h16);
        wait_busy(1'b1);
        chk(flash_req.erase, 1'b1);
        chk(flash_req.prog, 1'b0);
        chk(flash_req.row, 32'h012);
        wait_busy(1'b0);
        chk_blank();
        // Reset in mid-run with a loaded latch
        unlock(32'h26);
        repeat (4) @(posedge aclk);
        chk(latch_row[5], 32'h0199);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        chk({awready, wready, arready, bvalid, rvalid}, 32'h1C);
        chk(flash_req, 32'h0);
        chk_blank();
        rd(`OFS_CONTROL);
        chk(q, 32'h00);
        end_sim();
    end
endmodule : tb_flash_row_write_sequencer
